/* hdl/pdr_ramper.v */
`include "pdr_regs.vh"
module pdr_ramper #(
   parameter STEP_CYC = `PDR_STEP_CYC
) (
   // Clock and reset
   input  wire        clk,
   input  wire        nrst,
   // Control
   input  wire [2:0]  rate_sel,
   input  wire [10:0] target,
   // Ramped code
   output reg  [10:0] code
);
   reg  [31:0] cnt;
   wire [31:0] dwell;
   assign dwell = (STEP_CYC << rate_sel) - 32'h1;

   always @(posedge clk) begin
      if (!nrst) begin
         cnt  <= 32'h0;
         code <= 11'h000;
      end else if (code == target) begin
         cnt <= 32'h0;
      end else if (cnt >= dwell) begin
         cnt <= 32'h0;
         if (target > code)
            code <= code + 11'h001;
         else
            code <= code - 11'h001;
      end else begin
         cnt <= cnt + 32'h1;
      end
   end
endmodule

/* hdl/pdr_regs.vh */
`ifndef PDR_REGS_VH
`define PDR_REGS_VH
// Register index and byte address
`define PDR_IDX_PWM_CTRL     8'h12
`define PDR_ADDR_PWM_CTRL    10'h048
`define PDR_IDX_RAMP_CTRL    8'h13
`define PDR_ADDR_RAMP_CTRL   10'h04c
`define PDR_IDX_STATUS       8'h14
`define PDR_ADDR_STATUS      10'h050
// Control fields
`define PDR_RATE_HI          7
`define PDR_RATE_LO          6
`define PDR_HYST_HI          4
`define PDR_HYST_LO          2
`define PDR_PWM_EN_BIT       0
`define PDR_MODE_HI          2
`define PDR_MODE_LO          1
`define PDR_MODE_PWM         2'h1
`define PDR_RAMP_HI          7
`define PDR_RAMP_LO          5
// Reset values
`define PDR_PWM_CTRL_RST     8'h01
`define PDR_RAMP_CTRL_RST    8'h02
// Sample clock dividers from 100 MHz (800 kHz, 4 MHz, 25 MHz)
`define PDR_DIV_800K         8'h7d
`define PDR_DIV_4M           8'h19
`define PDR_DIV_24M          8'h04
// Timeout times in us and derived cycles at 100 MHz
`define PDR_TO_800K_US       25000
`define PDR_TO_4M_US         3000
`define PDR_TO_24M_US        600
`define PDR_CLK_MHZ          100
`define PDR_TO_800K_CYC      (`PDR_TO_800K_US * `PDR_CLK_MHZ)
`define PDR_TO_4M_CYC        (`PDR_TO_4M_US * `PDR_CLK_MHZ)
`define PDR_TO_24M_CYC       (`PDR_TO_24M_US * `PDR_CLK_MHZ)
// Step response 2 ms over 2047 codes: about 97 cycles (just under 1 us) per code
`define PDR_STEP_US          2000
`define PDR_STEP_CYC         ((`PDR_STEP_US * `PDR_CLK_MHZ) / 2047)
// Code width and full scale
`define PDR_CODE_W           11
`define PDR_CODE_MAX         11'h7ff
`endif

/* hdl/pdr_top.v */
// Behaviour
// - Sample PWM, duty to 11-bit code
// - Bits 7:6 select sample rate
// - Resolution limited by samples per period
// - Hysteresis 2^n codes, bits 4:2 (code caps n at 6, so n=7 gives 64)
// - Hysteresis only on direction reversal
// - Full-scale step in about 2 ms
// - No pulse in timeout: boost off
// - Timeout depends on sample rate
// - Eight programmable ramp rates
// - Ramp one code per step
// - Mode 01 uses PWM code only
// - Code zero gives zero current
//
// The implementer's own choice: register access over Avalon-MM.
`include "pdr_regs.vh"
module pdr_top #(
   parameter TO_800K = `PDR_TO_800K_CYC,
   parameter TO_4M   = `PDR_TO_4M_CYC,
   parameter TO_24M  = `PDR_TO_24M_CYC,
   parameter STEP_CYC = `PDR_STEP_CYC
) (
   // Clock and reset
   input  wire        clk,
   input  wire        nrst,
   // Avalon-MM slave
   input  wire [9:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   // PWM input
   input  wire        pwm_in,
   // Outputs
   output reg  [10:0] brightness_code,
   output reg         led_on,
   output reg         boost_en
);
   reg  [7:0]  pwm_ctrl;
   reg  [7:0]  ramp_ctrl;
   reg  [7:0]  div_cnt;
   reg  [7:0]  div_max;
   reg         samp_en;
   reg         pwm_q;
   reg  [21:0] hi_acc;
   reg  [21:0] per_acc;
   reg  [10:0] duty;
   reg         duty_vld;
   reg  [10:0] held;
   reg         dir_up;
   reg  [31:0] to_cnt;
   reg  [31:0] to_max;
   reg         timed_out;
   reg  [2:0]  hyst;
   reg  [11:0] hyst_amt;
   reg  [10:0] target;
   reg  [31:0] next_quot;
   wire [10:0] ramp_code;
   wire        acc;
   wire        rise;
   wire        pwm_en;

   assign acc    = avs_read | avs_write;
   assign rise   = pwm_in & ~pwm_q;
   assign pwm_en = pwm_ctrl[`PDR_PWM_EN_BIT];

   // Bus slave: one wait cycle, then answer
   always @(posedge clk) begin
      if (!nrst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0;
         pwm_ctrl        <= `PDR_PWM_CTRL_RST;
         ramp_ctrl       <= `PDR_RAMP_CTRL_RST;
      end else begin
         avs_waitrequest <= ~(acc & avs_waitrequest);
         if (acc & avs_waitrequest) begin
            avs_readdata <= 32'h0;
            if (avs_write & avs_byteenable[0]) begin
               if (avs_address == `PDR_ADDR_PWM_CTRL)
                  pwm_ctrl <= avs_writedata[7:0];
               if (avs_address == `PDR_ADDR_RAMP_CTRL)
                  ramp_ctrl <= avs_writedata[7:0];
            end
            if (avs_read) begin
               case (avs_address)
                  `PDR_ADDR_PWM_CTRL:  avs_readdata <= {24'h0, pwm_ctrl};
                  `PDR_ADDR_RAMP_CTRL: avs_readdata <= {24'h0, ramp_ctrl};
                  `PDR_ADDR_STATUS:    avs_readdata <= {20'h0, timed_out, ramp_code};
                  default:             avs_readdata <= 32'h0;
               endcase
            end
         end
      end
   end

   always @* begin
      case (pwm_ctrl[`PDR_RATE_HI:`PDR_RATE_LO])
         2'h0:    begin div_max = `PDR_DIV_800K; to_max = TO_800K; end
         2'h1:    begin div_max = `PDR_DIV_4M;   to_max = TO_4M;   end
         default: begin div_max = `PDR_DIV_24M;  to_max = TO_24M;  end
      endcase
   end

   // Sample clock enable
   always @(posedge clk) begin
      if (!nrst) begin
         div_cnt <= 8'h00;
         samp_en <= 1'b0;
      end else if (div_cnt >= div_max - 8'h01) begin
         div_cnt <= 8'h00;
         samp_en <= 1'b1;
      end else begin
         div_cnt <= div_cnt + 8'h01;
         samp_en <= 1'b0;
      end
   end

   // duty measurement, resolution set by sample count
   always @(posedge clk) begin
      if (!nrst) begin
         pwm_q    <= 1'b0;
         hi_acc   <= 22'h0;
         per_acc  <= 22'h0;
         duty_vld <= 1'b0;
      end else begin
         duty_vld <= 1'b0;
         if (samp_en) begin
            pwm_q <= pwm_in;
            if (rise) begin
               // Rise sample is itself high
               hi_acc   <= 22'h1;
               per_acc  <= 22'h1;
               duty_vld <= (per_acc != 22'h0);
            end else if (per_acc != 22'h3fffff) begin
               per_acc <= per_acc + 22'h1;
               if (pwm_in)
                  hi_acc <= hi_acc + 22'h1;
            end
         end
      end
   end

   // Duty code: high samples scaled to 2047 full scale
   always @* begin
      next_quot = 32'h0;
      if (per_acc != 22'h0)
         next_quot = ({10'h0, hi_acc} * 32'd2047 + {10'h0, per_acc} - 32'h1) / {10'h0, per_acc};
      if (next_quot > 32'h7ff)
         next_quot = 32'h7ff;
   end

   always @* begin
      hyst = pwm_ctrl[`PDR_HYST_HI:`PDR_HYST_LO];
      if (hyst == 3'h7)
         hyst = 3'h6;
      hyst_amt = 12'h1 << hyst;
   end

   always @(posedge clk) begin
      if (!nrst) begin
         duty      <= 11'h0;
         held      <= 11'h0;
         dir_up    <= 1'b1;
         to_cnt    <= 32'h0;
         timed_out <= 1'b0;
      end else begin
         if (samp_en & rise & (per_acc != 22'h0))
            duty <= next_quot[10:0];
         // reversal needs threshold, same direction follows
         if (duty_vld) begin
            if (dir_up & (duty > held))
               held <= duty;
            else if (~dir_up & (duty < held))
               held <= duty;
            else if (dir_up & ({1'b0, held} >= {1'b0, duty} + hyst_amt)) begin
               held   <= duty;
               dir_up <= 1'b0;
            end else if (~dir_up & ({1'b0, duty} >= {1'b0, held} + hyst_amt)) begin
               held   <= duty;
               dir_up <= 1'b1;
            end
         end
         // timeout per rate, resume on pulse
         if (~pwm_en | (samp_en & rise)) begin
            to_cnt    <= 32'h0;
            timed_out <= 1'b0;
         end else if (to_cnt >= to_max - 32'h1) begin
            timed_out <= 1'b1;
         end else begin
            to_cnt <= to_cnt + 32'h1;
         end
      end
   end

   // PWM only drives target in mode 01
   always @* begin
      target = 11'h0;
      if (pwm_en & ~timed_out & (ramp_ctrl[`PDR_MODE_HI:`PDR_MODE_LO] == `PDR_MODE_PWM))
         target = held;
   end

   pdr_ramper #(
      .STEP_CYC (STEP_CYC)
   ) i_pdr_ramper (
      .clk      (clk),
      .nrst     (nrst),
      .rate_sel (ramp_ctrl[`PDR_RAMP_HI:`PDR_RAMP_LO]),
      .target   (target),
      .code     (ramp_code)
   );

   always @(posedge clk) begin
      if (!nrst) begin
         brightness_code <= 11'h0;
         led_on          <= 1'b0;
         boost_en        <= 1'b0;
      end else begin
         brightness_code <= ramp_code;
         led_on          <= (ramp_code != 11'h0);
         boost_en        <= pwm_en & ~timed_out & (ramp_code != 11'h0);
      end
   end
endmodule

/* sim/pdr_pwm_src.sv */
module pdr_pwm_src (
   // Clock
   input  logic        clk,
   // Waveform
   input  logic        en,
   input  logic [15:0] high,
   input  logic [15:0] period,
   // Line, pulled low when idle
   output logic        pwm
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] cnt = 16'h0;
   initial pwm = 1'b0;
   always @(posedge clk) begin
      cnt <= (cnt + 16'h1 >= period) ? 16'h0 : cnt + 16'h1;
      pwm <= en && (cnt < high);
   end
endmodule

/* sim/pdr_top_assertions.sv */
module pdr_top_chk #(
   parameter TO_800K = 2000
) (
   // Clock and reset
   input logic        clk,
   input logic        nrst,
   // Bus
   input logic        avs_read,
   input logic        avs_write,
   input logic        avs_waitrequest,
   // Pins
   input logic        pwm_in,
   input logic [10:0] brightness_code,
   input logic        led_on,
   input logic        boost_en
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        last;
   logic [15:0] idle;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // Cycles since the line moved
   always @(posedge clk) begin
      last <= pwm_in;
      idle <= (!nrst || pwm_in != last) ? 16'h0 : idle + 16'h1;
   end
   property p_take; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
   a_take: assert property (p_take) else $error("no answer");
   property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
   a_one: assert property (p_one) else $error("long answer");
   property p_quiet; !avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest; endproperty
   a_quiet: assert property (p_quiet) else $error("stray answer");
   property p_step; $changed(brightness_code) |-> brightness_code - $past(brightness_code) == 11'h1
      || $past(brightness_code) - brightness_code == 11'h1; endproperty
   a_step: assert property (p_step) else $error("step not one");
   property p_dwell; $changed(brightness_code) |=> $stable(brightness_code); endproperty
   a_dwell: assert property (p_dwell) else $error("no dwell");
   property p_dark; (brightness_code == 11'h0) [*2] |-> !led_on && !boost_en; endproperty
   a_dark: assert property (p_dark) else $error("lit at zero");
   property p_lit; (brightness_code != 11'h0) [*2] |-> led_on; endproperty
   a_lit: assert property (p_lit) else $error("dark at code");
   property p_tmo; idle > TO_800K + 16 |-> !boost_en; endproperty
   a_tmo: assert property (p_tmo) else $error("boost on idle");
   cover property (avs_read && !avs_waitrequest);
   cover property ($fell(boost_en));
   cover property (brightness_code == 11'h600 && led_on);
endmodule

/* sim/test_pdr_top.sv */
module test_pdr_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic [9:0]  avs_address = 10'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        pwm_in;
   logic [10:0] brightness_code;
   logic        led_on;
   logic        boost_en;
   logic        en = 1'b0;
   logic [15:0] high = 16'h07d0;
   logic [31:0] q;
   int          fails = 0;
   int          checked = 0;
   int          cyc = 0;
   int          t;
   always #5 clk = ~clk;
   pdr_pwm_src i_pdr_pwm_src (.clk, .en, .high, .period(16'h0fa0), .pwm(pwm_in));
   pdr_top #(.TO_800K(6000), .TO_4M(5000), .TO_24M(4500), .STEP_CYC(2)) i_pdr_top (.clk, .nrst,
      .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
      .avs_waitrequest, .pwm_in, .brightness_code, .led_on, .boost_en);
   task automatic summarize();
      $display("checked=%0d fails=%0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] g, e);
      checked++;
      if (g !== e) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [3:0] be);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      avs_byteenable <= be;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0);
      cmp(n, 2);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic rd(input logic [9:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, 4'hf);
      cmp(q, e);
   endtask
   task automatic settle(input logic [10:0] e);
      t = 0;
      while (brightness_code !== e && t < 20000) begin
         @(posedge clk);
         t++;
      end
      cmp(brightness_code, e);
   endtask
   task automatic hold(input logic [10:0] e);
      repeat (9000) @(posedge clk);
      cmp(brightness_code, e);
   endtask
   // New width lands at a period start
   task automatic duty(input logic [15:0] h);
      @(posedge pwm_in);
      @(posedge clk);
      high <= h;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 99000) begin
         fails++;
         summarize();
      end
   end
   initial begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      rd(10'h048, 32'h01);
      rd(10'h04c, 32'h02);
      rd(10'h3fc, 32'h0);
      bus(1'b1, 10'h048, 32'hc1, 4'hf);
      bus(1'b1, 10'h048, 32'h0, 4'h0);
      rd(10'h048, 32'hc1);
      en <= 1'b1;
      settle(11'h400);
      rd(10'h050, 32'h400);
      bus(1'b1, 10'h04c, 32'h22, 4'hf);
      duty(16'h0bb8);
      while (brightness_code === 11'h400 && t < 40000) begin
         @(posedge clk);
         t++;
      end
      settle(11'h600);
      cmp(t, 511 * 4);
      bus(1'b1, 10'h04c, 32'h02, 4'hf);
      bus(1'b1, 10'h048, 32'hc9, 4'hf);
      duty(16'h0bb4);
      hold(11'h600);
      duty(16'h0bb0);
      settle(11'h5fc);
      duty(16'h0bac);
      settle(11'h5fa);
      bus(1'b1, 10'h048, 32'hdd, 4'hf);
      duty(16'h0be0);
      hold(11'h5fa);
      duty(16'h0c30);
      settle(11'h63d);
      cmp(boost_en, 1);
      en <= 1'b0;
      repeat (6100) @(posedge clk);
      cmp(boost_en, 0);
      settle(11'h0);
      en <= 1'b1;
      settle(11'h63d);
      cmp(boost_en, 1);
      cmp(led_on, 1);
      bus(1'b1, 10'h04c, 32'h0, 4'hf);
      settle(11'h0);
      cmp(led_on, 0);
      summarize();
   end
endmodule
bind pdr_top pdr_top_chk #(.TO_800K(TO_800K)) i_pdr_top_chk (.clk, .nrst, .avs_read, .avs_write,
   .avs_waitrequest, .pwm_in, .brightness_code, .led_on, .boost_en);
